//--- design/dtm_pkg.sv
package dtm_pkg;

  // ----------------------------------------------------------------
  // register map (avalon word addresses)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_HIST0  = 3'h2;
  localparam logic [2:0] REG_HIST3  = 3'h5;

  // ctrl fields
  localparam int CTRL_EXT_REQ   = 0;
  localparam int CTRL_LOOP_REF  = 1;
  localparam int CTRL_ONE_QUAD  = 2;
  localparam int CTRL_HS_FITTED = 3;
  localparam int CTRL_TUNE      = 4;
  localparam int CTRL_SER_LSB   = 5;
  localparam int CTRL_TRIP_RST  = 8;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [1:0] SER_MODE_LINK = 2'h3;

  // status fields
  localparam int STAT_TRIPPED = 8;
  localparam int STAT_MODE    = 9;

  // ----------------------------------------------------------------
  // trip codes, index order is priority order
  // ----------------------------------------------------------------
  localparam int NFLT = 21;
  localparam logic [NFLT-1:0][7:0] FLT_CODE = {
    8'h7b,  // 20 motor_winding_hot 123
    8'h69,  // 19 serial_link_timeout 105
    8'h7d,  // 18 internal_rail_trip 125
    8'h78,  // 17 mains_phase_missing 120
    8'h65,  // 16 phase_order_trip 101
    8'h83,  // 15 option_cpu_watchdog 131
    8'h7c,  // 14 main_cpu_watchdog 124
    8'h6b,  // 13 heatsink_overtemp 107
    8'h7a,  // 12 overload_integral_trip 122
    8'h6a,  // 11 field_overcurrent_trip 106
    8'h6c,  // 10 field_present_during_tune 108
    8'h76,  // 9 field_current_missing 118
    8'h6d,  // 8 speed_feedback_reversed 109
    8'h77,  // 7 speed_feedback_missing 119
    8'h66,  // 6 user_external_trip 102
    8'h67,  // 5 aux_supply_overload 103
    8'h68,  // 4 loop_reference_lost 104
    8'h7e,  // 3 armature_open_trip 126
    8'h79,  // 2 armature_overcurrent_trip 121
    8'h84,  // 1 stored_settings_corrupt 132
    8'h64   // 0 selftest_failure 100
  };
  localparam logic [7:0] OPT_CODE_MIN = 8'h28;
  localparam logic [7:0] OPT_CODE_MAX = 8'h45;
  localparam logic [7:0] CODE_NONE    = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_CYC     = FLASH_HALF_MS * 1000 * CLK_MHZ;
  localparam int SER_LOSS_MS   = 1000;
  localparam int SER_LOSS_CYC  = SER_LOSS_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DTM_RUN, DTM_TRIP, DTM_ADJUST} dtm_mode_e;

  typedef struct packed {
    logic selftest_fail;
    logic settings_err;
    logic arm_overcurrent;
    logic fire_advanced;
    logic arm_current_seen;
    logic loop_low;
    logic aux_overcurrent;
    logic tach_lost;
    logic enc_lost;
    logic polarity_bad;
    logic field_current_seen;
    logic field_overcurrent;
    logic field_phased_back;
    logic overload_full;
    logic heatsink_hot;
    logic main_wd;
    logic option_wd;
    logic phase_mismatch;
    logic phase_open;
    logic rail_bad;
    logic serial_rx_toggle;
    logic therm_above_trip;
    logic therm_below_reset;
  } dtm_pins_s;

  // healthy detector levels: field current flowing, thermistor cold
  localparam dtm_pins_s PINS_IDLE = 23'h001001;

  typedef struct packed {
    logic       halted_banner;
    logic       flash_on;
    logic [7:0] mnemonic_code;
  } dtm_disp_s;

endpackage

//--- design/dtm_trip_manager.sv
// Function
// - armature overcurrent detector trips code 121
// - advanced firing without armature current trips 126
// - loop reference below 3mA trips 104
// - selftest fault 100, corrupt settings 132
// - aux supply overcurrent trips code 103
// - external request flag set trips 102
// - no tacho and no encoder trips 119
// - reversed feedback trips 109, not single-quadrant
// - no field current trips code 118
// - field current during tuning trips 108
// - field overcurrent or phased-back current trips 106
// - overload accumulator at trip level trips 122
// - heatsink switch trips 107 when fitted
// - main watchdog 124, option watchdog 131
// - phase order 101, phase open 120, rail 125
// - serial silence in mode 3 trips 105
// - winding thermistor with hysteresis trips 123
// - option module codes 40 to 69
// - trip shows halted banner, flashing mnemonic
// - four newest trip codes kept, shift on trip
// - read-only values frozen while tripped
// - keys enter adjust, left at menu 00 returns
`timescale 1ns/1ps
`default_nettype none

module dtm_trip_manager #(
  parameter int FLASH_CYC    = dtm_pkg::FLASH_CYC,
  parameter int SER_LOSS_CYC = dtm_pkg::SER_LOSS_CYC,
  parameter int NKEY         = 5,
  parameter int LEFT_KEY     = 2
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [2:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire dtm_pkg::dtm_pins_s fault_pins,
  input  wire logic [NKEY-1:0]   key_pins,
  input  wire logic              menu_is_00,
  input  wire logic              opt_err_valid,
  input  wire logic [7:0]        opt_err_code,
  output logic                   fire_enable,
  output logic                   freeze_ro,
  output logic                   hist_update,
  output dtm_pkg::dtm_disp_s     display
);

  if (FLASH_CYC < 2 || SER_LOSS_CYC < 2 || LEFT_KEY >= NKEY || LEFT_KEY < 0 || NKEY < 1) begin : g_bad
    $error("dtm_trip_manager: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  dtm_pkg::dtm_pins_s pins_m_r;
  dtm_pkg::dtm_pins_s pins_s_r;
  logic [NKEY-1:0]    key_m_r;
  logic [NKEY-1:0]    key_s_r;
  logic [NKEY-1:0]    key_d_r;
  logic               ser_tog_d_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // idle levels, else a zero field bit trips at once
      pins_m_r    <= dtm_pkg::PINS_IDLE;
      pins_s_r    <= dtm_pkg::PINS_IDLE;
      key_m_r     <= '0;
      key_s_r     <= '0;
      key_d_r     <= '0;
      ser_tog_d_r <= 1'b0;
    end else begin
      pins_m_r    <= fault_pins;
      pins_s_r    <= pins_m_r;
      key_m_r     <= key_pins;
      key_s_r     <= key_m_r;
      key_d_r     <= key_s_r;
      ser_tog_d_r <= pins_s_r.serial_rx_toggle;
    end
  end

  logic [NKEY-1:0] key_press;
  assign key_press = key_s_r & ~key_d_r;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [6:0] ctrl_r;
  logic       bus_wr;
  logic       bus_rd;
  logic       trip_reset;

  assign bus_wr     = avs_write & ~avs_waitrequest;
  assign bus_rd     = avs_read & avs_waitrequest;
  assign trip_reset = bus_wr & (avs_address == dtm_pkg::REG_CTRL) & avs_byteenable[1]
                      & avs_writedata[dtm_pkg::CTRL_TRIP_RST];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= dtm_pkg::CTRL_RESET;
    end else if (bus_wr && avs_address == dtm_pkg::REG_CTRL && avs_byteenable[0]) begin
      ctrl_r <= avs_writedata[6:0];
    end
  end

  logic [1:0] ser_mode;
  assign ser_mode = ctrl_r[dtm_pkg::CTRL_SER_LSB +: 2];

  // ----------------------------------------------------------------
  // serial silence timer and thermistor hysteresis
  // ----------------------------------------------------------------
  logic [31:0] ser_cnt_r;
  logic        ser_lost_r;
  logic        winding_hot_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ser_cnt_r  <= '0;
      ser_lost_r <= 1'b0;
    end else if (ser_mode != dtm_pkg::SER_MODE_LINK ||
                 pins_s_r.serial_rx_toggle != ser_tog_d_r) begin
      ser_cnt_r  <= '0;
      ser_lost_r <= 1'b0;
    end else if (ser_cnt_r == 32'(SER_LOSS_CYC - 1)) begin
      ser_lost_r <= 1'b1;
    end else begin
      ser_cnt_r <= ser_cnt_r + 32'h1;
    end
  end

  // set above the trip threshold, release only below the lower reset one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      winding_hot_r <= 1'b0;
    end else if (pins_s_r.therm_above_trip) begin
      winding_hot_r <= 1'b1;
    end else if (pins_s_r.therm_below_reset) begin
      winding_hot_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // fault qualification
  // ----------------------------------------------------------------
  logic [dtm_pkg::NFLT-1:0] flt;

  always_comb begin
    flt     = '0;
    flt[0]  = pins_s_r.selftest_fail;
    flt[1]  = pins_s_r.settings_err;
    flt[2]  = pins_s_r.arm_overcurrent;
    flt[3]  = pins_s_r.fire_advanced & ~pins_s_r.arm_current_seen;
    flt[4]  = ctrl_r[dtm_pkg::CTRL_LOOP_REF] & pins_s_r.loop_low;
    flt[5]  = pins_s_r.aux_overcurrent;
    flt[6]  = ctrl_r[dtm_pkg::CTRL_EXT_REQ];
    flt[7]  = pins_s_r.tach_lost & pins_s_r.enc_lost;
    flt[8]  = pins_s_r.polarity_bad & ~ctrl_r[dtm_pkg::CTRL_ONE_QUAD];
    flt[9]  = ~pins_s_r.field_current_seen;
    flt[10] = ctrl_r[dtm_pkg::CTRL_TUNE] & pins_s_r.field_current_seen;
    flt[11] = pins_s_r.field_overcurrent |
              (pins_s_r.field_current_seen & pins_s_r.field_phased_back);
    flt[12] = pins_s_r.overload_full;
    flt[13] = ctrl_r[dtm_pkg::CTRL_HS_FITTED] & pins_s_r.heatsink_hot;
    flt[14] = pins_s_r.main_wd;
    flt[15] = pins_s_r.option_wd;
    flt[16] = pins_s_r.phase_mismatch;
    flt[17] = pins_s_r.phase_open;
    flt[18] = pins_s_r.rail_bad;
    flt[19] = ser_lost_r;
    flt[20] = winding_hot_r;
  end

  // lowest index wins when several assert in one cycle
  logic       any_flt;
  logic [7:0] flt_code;

  always_comb begin
    any_flt  = 1'b0;
    flt_code = dtm_pkg::CODE_NONE;
    for (int i = dtm_pkg::NFLT - 1; i >= 0; i--) begin
      if (flt[i]) begin
        any_flt  = 1'b1;
        flt_code = dtm_pkg::FLT_CODE[i];
      end
    end
    if (!any_flt && opt_err_valid && opt_err_code >= dtm_pkg::OPT_CODE_MIN &&
        opt_err_code <= dtm_pkg::OPT_CODE_MAX) begin
      any_flt  = 1'b1;
      flt_code = opt_err_code;
    end
  end

  // ----------------------------------------------------------------
  // trip latch
  // ----------------------------------------------------------------
  logic       tripped_r;
  logic [7:0] code_r;
  logic       new_trip;

  // a fault present at the reset strobe retrips at once
  assign new_trip = any_flt & (~tripped_r | trip_reset);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tripped_r <= 1'b0;
      code_r    <= dtm_pkg::CODE_NONE;
    end else if (new_trip) begin
      tripped_r <= 1'b1;
      code_r    <= flt_code;
    end else if (trip_reset) begin
      tripped_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fire_enable <= 1'b0;
      freeze_ro   <= 1'b0;
    end else begin
      fire_enable <= ~(tripped_r | new_trip);
      freeze_ro   <= tripped_r | new_trip;
    end
  end

  // ----------------------------------------------------------------
  // trip history
  // ----------------------------------------------------------------
  // software reloads the saved copy after power-up, a trip wins a clash
  logic [3:0][7:0] hist_r;
  logic [1:0]      hist_idx;

  assign hist_idx = 2'(avs_address - dtm_pkg::REG_HIST0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_r      <= '0;
      hist_update <= 1'b0;
    end else begin
      hist_update <= new_trip;
      if (new_trip) begin
        hist_r <= {hist_r[2:0], flt_code};
      end else if (bus_wr && avs_byteenable[0] && avs_address >= dtm_pkg::REG_HIST0 &&
                   avs_address <= dtm_pkg::REG_HIST3) begin
        hist_r[hist_idx] <= avs_writedata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // operator mode
  // ----------------------------------------------------------------
  dtm_pkg::dtm_mode_e mode_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= dtm_pkg::DTM_RUN;
    end else if (new_trip) begin
      mode_r <= dtm_pkg::DTM_TRIP;
    end else if (trip_reset) begin
      mode_r <= dtm_pkg::DTM_RUN;
    end else begin
      unique case (mode_r)
        dtm_pkg::DTM_RUN: begin
          mode_r <= dtm_pkg::DTM_RUN;
        end
        dtm_pkg::DTM_TRIP: begin
          if (|key_press) begin
            mode_r <= dtm_pkg::DTM_ADJUST;
          end
        end
        dtm_pkg::DTM_ADJUST: begin
          if (key_press[LEFT_KEY] && menu_is_00) begin
            mode_r <= dtm_pkg::DTM_TRIP;
          end
        end
        default: begin
          mode_r <= dtm_pkg::DTM_TRIP;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // display
  // ----------------------------------------------------------------
  logic [31:0] flash_cnt_r;
  logic        flash_ph_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_cnt_r <= '0;
      flash_ph_r  <= 1'b1;
    end else if (!tripped_r || flash_cnt_r == 32'(FLASH_CYC - 1)) begin
      flash_cnt_r <= '0;
      flash_ph_r  <= ~tripped_r | ~flash_ph_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      display <= '0;
    end else begin
      display.halted_banner <= tripped_r & (mode_r == dtm_pkg::DTM_TRIP);
      display.flash_on      <= tripped_r & flash_ph_r;
      display.mnemonic_code <= tripped_r ? code_r : dtm_pkg::CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave, one wait state on every access
  // ----------------------------------------------------------------
  logic [31:0] rd_val;

  always_comb begin
    rd_val = '0;
    if (avs_address == dtm_pkg::REG_CTRL) begin
      rd_val[6:0] = ctrl_r;
    end else if (avs_address == dtm_pkg::REG_STATUS) begin
      rd_val[7:0]                        = code_r;
      rd_val[dtm_pkg::STAT_TRIPPED]      = tripped_r;
      rd_val[dtm_pkg::STAT_MODE +: 2]    = mode_r;
    end else if (avs_address >= dtm_pkg::REG_HIST0 && avs_address <= dtm_pkg::REG_HIST3) begin
      rd_val[7:0] = hist_r[hist_idx];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (bus_rd) begin
        avs_readdata <= rd_val;
      end
    end
  end

endmodule

`default_nettype wire

//--- sim/dtm_fault_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtm_fault_model (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [22:0]   flip,
  input  wire logic          silent,
  output dtm_pkg::dtm_pins_s pins
);
  // ----
  // healthy plant: field current flows, thermistor cold
  // ----
  logic rx_tog_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      rx_tog_r <= 1'b0;
    else if (!silent)
      rx_tog_r <= ~rx_tog_r;
  end
  // flip inverts single detectors, so the no-tacho-and-no-encoder fault needs both bits
  assign pins = dtm_pkg::dtm_pins_s'(23'h001001 ^ flip ^ {20'h0, rx_tog_r, 2'h0});
endmodule
`default_nettype wire

//--- sim/dtm_trip_manager_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dtm_trip_manager_assertions #(
  parameter int FLASH_CYC    = 4,
  parameter int SER_LOSS_CYC = 8,
  parameter int NKEY         = 5,
  parameter int LEFT_KEY     = 2
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [2:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [3:0]         avs_byteenable,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire dtm_pkg::dtm_pins_s fault_pins,
  input wire logic [NKEY-1:0]    key_pins,
  input wire logic               menu_is_00,
  input wire logic               opt_err_valid,
  input wire logic [7:0]         opt_err_code,
  input wire logic               fire_enable,
  input wire logic               freeze_ro,
  input wire logic               hist_update,
  input wire dtm_pkg::dtm_disp_s display
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_fire_blocked: assert property (freeze_ro && $past(freeze_ro) |-> !fire_enable)
    else $error("firing allowed while tripped");
  a_idle_display: assert property (!freeze_ro && !$past(freeze_ro) |->
    !display.flash_on && display.mnemonic_code == 8'h00)
    else $error("display active without trip");
  a_banner_trip: assert property (display.halted_banner |-> freeze_ro)
    else $error("banner without trip");
  // display lags the latch one edge; a trip reset write may retrip
  a_code_held: assert property (freeze_ro && $past(freeze_ro) &&
    $past(freeze_ro, 2) && !$past(avs_write, 2) |-> $stable(display.mnemonic_code))
    else $error("latched code changed");
  a_code_shown: assert property ($rose(freeze_ro) |=> display.mnemonic_code != 8'h00)
    else $error("trip without code");
  a_hist_pulse: assert property (hist_update |=> !hist_update)
    else $error("history pulse too long");
  a_hist_trip: assert property (hist_update |-> freeze_ro)
    else $error("history shift without trip");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus answer late");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  c_trip: cover property ($rose(freeze_ro));
  c_hist: cover property (hist_update);
  c_flash: cover property (freeze_ro && $changed(display.flash_on));
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic               clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [2:0]         avs_address;
  logic [31:0]        avs_writedata, avs_readdata;
  logic [3:0]         avs_byteenable;
  dtm_pkg::dtm_pins_s fault_pins;
  dtm_pkg::dtm_disp_s display;
  logic [4:0]         key_pins;
  logic               menu_is_00, opt_err_valid, fire_enable, freeze_ro, hist_update;
  logic               silent;
  logic [7:0]         opt_err_code;
  logic [22:0]        flip;
  logic [7:0]         hq[$];
  int                 n_errors, total_checks, n_hist, n_trip, cyc;

  dtm_trip_manager #(.FLASH_CYC(4), .SER_LOSS_CYC(8)) i_dtm_trip_manager (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fault_pins(fault_pins), .key_pins(key_pins), .menu_is_00(menu_is_00),
    .opt_err_valid(opt_err_valid), .opt_err_code(opt_err_code),
    .fire_enable(fire_enable), .freeze_ro(freeze_ro), .hist_update(hist_update),
    .display(display));
  dtm_fault_model i_dtm_fault_model (
    .clk(clk), .rst(rst), .flip(flip), .silent(silent), .pins(fault_pins));

  // ----
  // helpers
  // ----
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ceiling far above the roughly 1300 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (hist_update === 1'b1) n_hist++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic we, input logic [2:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    avs_read <= !we;
    avs_write <= we;
    avs_address <= a;
    avs_writedata <= wd;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  task automatic rdc(input string nm, input logic [2:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(nm, e, d);
  endtask
  task automatic wait_frz(input logic v);
    for (int i = 0; i < 60 && freeze_ro !== v; i++) @(negedge clk);
  endtask
  task automatic clear_trip(input logic [7:0] code);
    wr(3'h0, 32'h100);
    wait_frz(1'b0);
    repeat (2) @(negedge clk);
    chk("fire", 32'h1, fire_enable);
    hq.push_front(code);
    n_trip++;
  endtask

  // ----
  // scenarios
  // ----
  task automatic regs();
    rdc("ctrl", 3'h0, 32'h0);
    wr(3'h0, 32'h16e);
    rdc("ctrl", 3'h0, 32'h6e);
    wr(3'h1, 32'hffff);
    rdc("status", 3'h1, 32'h0);
    wr(3'h7, 32'hff);
    rdc("unmapped", 3'h7, 32'h0);
    rdc("unmapped", 3'h6, 32'h0);
    wr(3'h5, 32'ha5);
    rdc("hist3", 3'h5, 32'ha5);
    wr(3'h0, 32'h0);
  endtask
  task automatic run_trip(input logic [22:0] m, input logic [31:0] c, input logic s,
                          input logic [7:0] code);
    logic p;
    int n;
    wr(3'h0, c);
    @(posedge clk);
    flip <= m;
    silent <= s;
    wait_frz(1'b1);
    // display follows the latch by one edge
    @(negedge clk);
    chk("code", code, display.mnemonic_code);
    chk("fire", 32'h0, fire_enable);
    chk("banner", 32'h1, display.halted_banner);
    p = display.flash_on;
    n = 0;
    repeat (8) begin
      @(negedge clk);
      if (display.flash_on !== p) n++;
      p = display.flash_on;
    end
    chk("flashes", 32'h2, n);
    rdc("status", 3'h1, 32'h300 | code);
    @(posedge clk);
    flip <= 23'h0;
    silent <= 1'b0;
    // control bits are fault causes too; the reset strobe sees the old ones
    wr(3'h0, 32'h0);
    repeat (8) @(negedge clk);
    chk("held", 32'h1, freeze_ro);
    clear_trip(code);
  endtask
  task automatic no_trip(input logic [22:0] m, input logic [31:0] c, input logic s);
    wr(3'h0, c);
    @(posedge clk);
    flip <= m;
    silent <= s;
    repeat (24) @(negedge clk);
    chk("no trip", 32'h0, freeze_ro);
    @(posedge clk);
    flip <= 23'h0;
    silent <= 1'b0;
    wr(3'h0, 32'h0);
  endtask
  task automatic opt_case(input logic [7:0] code, input logic acc);
    @(posedge clk);
    opt_err_valid <= 1'b1;
    opt_err_code <= code;
    @(posedge clk);
    opt_err_valid <= 1'b0;
    repeat (6) @(negedge clk);
    chk("opt trip", acc, freeze_ro);
    if (acc) begin
      chk("opt code", code, display.mnemonic_code);
      clear_trip(code);
    end
  endtask
  task automatic first_latch();
    @(posedge clk);
    flip <= 23'h000008;
    wait_frz(1'b1);
    @(posedge clk);
    flip <= 23'h500008;
    opt_err_valid <= 1'b1;
    opt_err_code <= 8'h30;
    @(posedge clk);
    opt_err_valid <= 1'b0;
    repeat (8) @(negedge clk);
    chk("first code", 32'h7d, display.mnemonic_code);
    @(posedge clk);
    flip <= 23'h0;
    repeat (6) @(negedge clk);
    clear_trip(8'h7d);
  endtask
  task automatic press(input int k, input logic [31:0] st);
    @(posedge clk);
    key_pins <= 5'h01 << k;
    repeat (4) @(posedge clk);
    key_pins <= 5'h00;
    repeat (4) @(posedge clk);
    rdc("mode", 3'h1, st);
  endtask
  task automatic keys();
    wr(3'h0, 32'h1);
    wait_frz(1'b1);
    for (int k = 0; k < 5; k++) begin
      press(k, 32'h566);
      chk("banner adj", 32'h0, display.halted_banner);
      press(2, 32'h566);
      menu_is_00 <= 1'b1;
      press(2, 32'h366);
      menu_is_00 <= 1'b0;
    end
    wr(3'h0, 32'h0);
    clear_trip(8'h66);
  endtask

  initial begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'h3;
    {key_pins, menu_is_00, opt_err_valid, opt_err_code, flip, silent} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    regs();
    run_trip(23'h100000, 32'h0, 1'b0, 8'h79);
    run_trip(23'h080000, 32'h0, 1'b0, 8'h7e);
    run_trip(23'h020000, 32'h2, 1'b0, 8'h68);
    run_trip(23'h400000, 32'h0, 1'b0, 8'h64);
    run_trip(23'h200000, 32'h0, 1'b0, 8'h84);
    run_trip(23'h010000, 32'h0, 1'b0, 8'h67);
    run_trip(23'h000000, 32'h1, 1'b0, 8'h66);
    run_trip(23'h00c000, 32'h0, 1'b0, 8'h77);
    run_trip(23'h002000, 32'h0, 1'b0, 8'h6d);
    run_trip(23'h001000, 32'h0, 1'b0, 8'h76);
    run_trip(23'h000000, 32'h10, 1'b0, 8'h6c);
    run_trip(23'h000800, 32'h0, 1'b0, 8'h6a);
    run_trip(23'h000400, 32'h0, 1'b0, 8'h6a);
    run_trip(23'h000200, 32'h0, 1'b0, 8'h7a);
    run_trip(23'h000100, 32'h8, 1'b0, 8'h6b);
    run_trip(23'h000080, 32'h0, 1'b0, 8'h7c);
    run_trip(23'h000040, 32'h0, 1'b0, 8'h83);
    run_trip(23'h000020, 32'h0, 1'b0, 8'h65);
    run_trip(23'h000010, 32'h0, 1'b0, 8'h78);
    run_trip(23'h000008, 32'h0, 1'b0, 8'h7d);
    run_trip(23'h000000, 32'h60, 1'b1, 8'h69);
    run_trip(23'h000003, 32'h0, 1'b0, 8'h7b);
    run_trip(23'h400008, 32'h0, 1'b0, 8'h64);
    no_trip(23'h020000, 32'h0, 1'b0);
    no_trip(23'h002000, 32'h4, 1'b0);
    no_trip(23'h000100, 32'h0, 1'b0);
    no_trip(23'h000000, 32'h40, 1'b1);
    opt_case(8'h28, 1'b1);
    opt_case(8'h45, 1'b1);
    opt_case(8'h27, 1'b0);
    opt_case(8'h46, 1'b0);
    first_latch();
    keys();
    for (int i = 0; i < 4; i++) rdc("hist", 3'(2 + i), {24'h0, hq[i]});
    chk("hist pulses", n_trip, n_hist);
    conclude();
  end
endmodule
bind dtm_trip_manager dtm_trip_manager_assertions #(.FLASH_CYC(FLASH_CYC),
  .SER_LOSS_CYC(SER_LOSS_CYC), .NKEY(NKEY), .LEFT_KEY(LEFT_KEY)) i_chk (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_pins(fault_pins),
  .key_pins(key_pins), .menu_is_00(menu_is_00), .opt_err_valid(opt_err_valid),
  .opt_err_code(opt_err_code), .fire_enable(fire_enable), .freeze_ro(freeze_ro),
  .hist_update(hist_update), .display(display));
`default_nettype wire
